// [rtl/pix_top.sv]
`timescale 1ns/1ps
`include "pix_regs.svh"

module pix_top #(
  parameter int NUM_USED = `PIX_NUM_USED,
  parameter int VEC_W    = `PIX_VEC_W
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  // peripheral side
  input  wire logic [`PIX_NUM_REQ-1:0]  periph_req,
  input  wire logic [`PIX_NUM_REQ-1:0]  req_enable,
  // vector table write
  input  wire logic                     vec_wr_en,
  input  wire logic [`PIX_IDX_W-1:0]    vec_wr_idx,
  input  wire logic [VEC_W-1:0]         vec_wr_data,
  // cpu interrupt lines
  output logic      [`PIX_NUM_LINES-1:0] cpu_irq_q,
  // cpu acknowledge and vector fetch
  input  wire logic                     cpu_ack,
  input  wire logic [`PIX_LINE_W-1:0]   cpu_ack_line,
  output logic                          vec_valid_q,
  output logic                          vec_spurious_q,
  output logic      [`PIX_IDX_W-1:0]    vec_idx_q,
  output logic      [VEC_W-1:0]         vec_data_q
);

  localparam int NREQ  = `PIX_NUM_REQ;
  localparam int NLINE = `PIX_NUM_LINES;
  localparam int GW    = `PIX_GRP_W;

  logic [NREQ-1:0]  used_mask;
  logic [NREQ-1:0]  set_vec;
  logic [NREQ-1:0]  act_vec;
  logic [NREQ-1:0]  clr_vec;
  logic [NREQ-1:0]  pend_q;
  logic [NREQ-1:0]  pend_d;
  logic [15:0]      grp_any;
  pix_pkg::pix_bit_t grp_bit [16];
  logic             line_ok;
  logic             ack_hit;
  pix_pkg::pix_idx_t win_idx;
  logic [NLINE-1:0] irq_d;
  logic             vec_valid_d;
  logic             vec_spurious_d;
  pix_pkg::pix_idx_t vec_idx_d;

  // ************************************************************
  // request qualification
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NREQ; gi++)
    begin : g_used
      assign used_mask[gi] = (gi < NUM_USED);
    end
  endgenerate

  always_comb
  begin
    set_vec = periph_req & req_enable & used_mask;
    act_vec = pend_q & req_enable;
  end

  // ************************************************************
  // per group priority
  // ************************************************************
  genvar gg;
  generate
    for (gg = 0; gg < 16; gg++)
    begin : g_grp
      if (gg < NLINE)
      begin : g_real
        assign grp_any[gg] = |act_vec[gg*GW +: GW];
        assign grp_bit[gg] = pix_pkg::pix_lowest8(act_vec[gg*GW +: GW]);
      end
      else
      begin : g_pad
        assign grp_any[gg] = 1'b0;
        assign grp_bit[gg] = 3'h0;
      end
    end
  endgenerate

  // ************************************************************
  // acknowledge and pending latch
  // ************************************************************
  // a disabled bit stays pending; it is hidden, not lost
  always_comb
  begin
    line_ok = (int'(cpu_ack_line) < NLINE);
    ack_hit = cpu_ack && line_ok && grp_any[cpu_ack_line];
    win_idx = {cpu_ack_line, grp_bit[cpu_ack_line]};
    clr_vec = '0;
    if (ack_hit)
    begin
      clr_vec = NREQ'(1) << win_idx;
    end
    // a new request in the clear cycle survives
    pend_d         = (pend_q & ~clr_vec) | set_vec;
    irq_d          = grp_any[NLINE-1:0];
    vec_valid_d    = ack_hit;
    vec_spurious_d = cpu_ack && !ack_hit;
    vec_idx_d      = ack_hit ? win_idx : vec_idx_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pend_q         <= `PIX_PEND_RST;
      cpu_irq_q      <= `PIX_IRQ_RST;
      vec_valid_q    <= 1'b0;
      vec_spurious_q <= 1'b0;
      vec_idx_q      <= `PIX_IDX_RST;
    end
    else
    begin
      pend_q         <= pend_d;
      cpu_irq_q      <= irq_d;
      vec_valid_q    <= vec_valid_d;
      vec_spurious_q <= vec_spurious_d;
      vec_idx_q      <= vec_idx_d;
    end
  end

  // ************************************************************
  // vector table
  // ************************************************************
  pix_vec_ram #(
    .DEPTH (NREQ),
    .W     (VEC_W)
  ) u_vec_ram (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .wr_en     (vec_wr_en),
    .wr_addr   (vec_wr_idx),
    .wr_data   (vec_wr_data),
    .rd_en     (ack_hit),
    .rd_addr   (win_idx),
    .rd_data_q (vec_data_q)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  logic [NREQ-1:0] lower_mask;
  always_comb
  begin
    lower_mask = (NREQ'(1) << win_idx) - NREQ'(1);
  end

  property p_unused_quiet;
    (pend_q & ~used_mask) == '0;
  endproperty
  a_unused_quiet: assert property (p_unused_quiet)
    else $error("unused request became pending");

  property p_set_latched;
    (set_vec != '0) |=> ((pend_q & $past(set_vec)) == $past(set_vec));
  endproperty
  a_set_latched: assert property (p_set_latched)
    else $error("enabled request not latched");

  property p_hold_until_ack;
    ##1 (($past(pend_q) & ~$past(clr_vec) & ~pend_q) == '0);
  endproperty
  a_hold_until_ack: assert property (p_hold_until_ack)
    else $error("pending bit lost without ack");

  property p_lowest_first;
    ack_hit |-> ((act_vec & lower_mask & ({{(NREQ-GW){1'b0}}, {GW{1'b1}}}
                 << (GW * int'(cpu_ack_line)))) == '0);
  endproperty
  a_lowest_first: assert property (p_lowest_first)
    else $error("lower pending request skipped");

  property p_ack_answer;
    ack_hit |=> vec_valid_q && !vec_spurious_q && (vec_idx_q == $past(win_idx));
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("vector not presented one cycle after ack");

  property p_spurious;
    (cpu_ack && !ack_hit) |=> vec_spurious_q && !vec_valid_q;
  endproperty
  a_spurious: assert property (p_spurious)
    else $error("empty ack not flagged");

  property p_vec_written;
    vec_wr_en ##1 (ack_hit && (win_idx == $past(vec_wr_idx)))
      |=> (vec_data_q == $past(vec_wr_data, 2));
  endproperty
  a_vec_written: assert property (p_vec_written)
    else $error("fetched vector differs from written one");

  generate
    for (gg = 0; gg < NLINE; gg++)
    begin : g_line_chk
      property p_line_map;
        ##1 (cpu_irq_q[gg] == $past(|(pend_q[gg*GW +: GW] & req_enable[gg*GW +: GW])));
      endproperty
      a_line_map: assert property (p_line_map)
        else $error("cpu line does not follow enabled pending group");
    end
  endgenerate

  c_ack_hit:   cover property (ack_hit ##1 vec_valid_q);
  c_spurious:  cover property (cpu_ack && !ack_hit);
  c_two_lines: cover property ($countones(cpu_irq_q) >= 2);
  c_set_clear: cover property (ack_hit && ((set_vec & clr_vec) != '0));

endmodule // pix_top

// [pkg/pix_regs.svh]
`ifndef PIX_REGS_SVH
`define PIX_REGS_SVH

// ************************************************************
// sizes
// ************************************************************
`define PIX_NUM_REQ    96
`define PIX_GRP_W      8
`define PIX_NUM_LINES  12
`define PIX_NUM_USED   45
`define PIX_VEC_W      22
`define PIX_IDX_W      7
`define PIX_LINE_W     4

// ************************************************************
// reset values and timing
// ************************************************************
`define PIX_PEND_RST   96'h0
`define PIX_IRQ_RST    12'h000
`define PIX_IDX_RST    7'h00
`define PIX_CPU_FETCH_CYC 8

`endif

// [pkg/pix_pkg.sv]
`include "pix_regs.svh"

package pix_pkg;

  typedef logic [`PIX_IDX_W-1:0]  pix_idx_t;
  typedef logic [`PIX_LINE_W-1:0] pix_line_t;
  typedef logic [2:0]             pix_bit_t;

  // lowest set bit of one group; zero when none set
  function automatic pix_bit_t pix_lowest8(input logic [7:0] v);
    pix_bit_t r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

endpackage

// [rtl/pix_vec_ram.sv]
`timescale 1ns/1ps
`include "pix_regs.svh"

module pix_vec_ram #(
  parameter int DEPTH = `PIX_NUM_REQ,
  parameter int W     = `PIX_VEC_W
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // write port
  input  wire logic                 wr_en,
  input  wire logic [`PIX_IDX_W-1:0] wr_addr,
  input  wire logic [W-1:0]         wr_data,
  // read port, one cycle latency
  input  wire logic                 rd_en,
  input  wire logic [`PIX_IDX_W-1:0] rd_addr,
  output logic      [W-1:0]         rd_data_q
);

  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] rd_data_d;

  // ************************************************************
  // read path
  // ************************************************************
  // same-cycle write and read of one entry returns the old vector
  always_comb
  begin
    rd_data_d = rd_data_q;
    if (rd_en && (int'(rd_addr) < DEPTH))
    begin
      rd_data_d = mem[rd_addr];
    end
  end

  // no reset on the array: contents are software's job
  always_ff @(posedge clk_sys)
  begin
    if (wr_en && (int'(wr_addr) < DEPTH))
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_data_q <= '0;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

endmodule // pix_vec_ram

// [tb/pix_cpu_model.sv]
`timescale 1ns/1ps
`include "pix_regs.svh"

module pix_cpu_model (
  // clock
  input  wire logic       clk_sys,
  // bench command
  input  wire logic       go,
  input  wire logic [3:0] go_line,
  input  wire logic [1:0] go_wait,
  output logic            done,
  output logic            late,
  // device side
  output logic            cpu_ack,
  output logic [3:0]      cpu_ack_line,
  input  wire logic       ans
);
  int n;

  initial
  begin
    cpu_ack = 1'b0;
    cpu_ack_line = 4'h0;
    done = 1'b0;
    late = 1'b0;
  end

  // slow or prompt start, one-cycle take, then bounded fetch
  always @(posedge go)
  begin
    done = 1'b0;
    repeat (go_wait)
    begin
      @(posedge clk_sys);
      #1;
    end
    cpu_ack = 1'b1;
    cpu_ack_line = go_line;
    @(posedge clk_sys);
    #1;
    cpu_ack = 1'b0;
    // released line shows garbage, not the last value
    cpu_ack_line = ~go_line;
    n = 0;
    while (!ans && n < `PIX_CPU_FETCH_CYC)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    late = !ans;
    done = 1'b1;
  end
endmodule // pix_cpu_model

// [tb/tb_peripheral_irq_expander.sv]
`timescale 1ns/1ps

module tb_peripheral_irq_expander;
  logic        clk_sys, reset, vec_wr_en, cpu_ack, vec_valid_q, vec_spurious_q;
  logic [95:0] periph_req, req_enable;
  logic [6:0]  vec_wr_idx, vec_idx_q;
  logic [21:0] vec_wr_data, vec_data_q;
  logic [11:0] cpu_irq_q;
  logic [3:0]  cpu_ack_line, go_line;
  logic [1:0]  go_wait;
  logic        go, done, late;
  logic [21:0] vt[96];
  logic [30:0] q[$];
  int          n_fail, comparisons;

  pix_top i_pix_top (.clk_sys(clk_sys), .reset(reset), .periph_req(periph_req),
    .req_enable(req_enable), .vec_wr_en(vec_wr_en), .vec_wr_idx(vec_wr_idx),
    .vec_wr_data(vec_wr_data), .cpu_irq_q(cpu_irq_q), .cpu_ack(cpu_ack),
    .cpu_ack_line(cpu_ack_line), .vec_valid_q(vec_valid_q),
    .vec_spurious_q(vec_spurious_q), .vec_idx_q(vec_idx_q), .vec_data_q(vec_data_q));

  pix_cpu_model i_pix_cpu_model (.clk_sys(clk_sys), .go(go), .go_line(go_line),
    .go_wait(go_wait), .done(done), .late(late), .cpu_ack(cpu_ack),
    .cpu_ack_line(cpu_ack_line), .ans(vec_valid_q | vec_spurious_q));

  always #5 clk_sys = ~clk_sys;

  task automatic check(input logic [30:0] got, input logic [30:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic ack_line(input int g);
    go_line = 4'(g);
    go_wait = 2'($urandom);
    go = 1'b1;
    @(posedge clk_sys);
    #1;
    go = 1'b0;
    wait (done);
    check(31'(late), 31'h0);
    // spacing keeps a falling line from being re-taken
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ****************
  // answer watcher
  // ****************
  always @(negedge clk_sys)
  begin
    if (vec_valid_q === 1'b1 || vec_spurious_q === 1'b1)
      check({vec_spurious_q, vec_valid_q, vec_spurious_q ? 29'h0 : {vec_idx_q, vec_data_q}},
            q.size() ? q.pop_front() : 'x);
  end

  initial
  begin
    #200us;
    n_fail++;
    tally_and_finish();
  end

  // ****************
  // main sequence
  // ****************
  initial
  begin
    logic [7:0] p, e, pend;
    int g, b;
    clk_sys = 1'b0;
    reset = 1'b1;
    periph_req = '0;
    req_enable = '0;
    vec_wr_en = 1'b0;
    vec_wr_idx = 7'h00;
    vec_wr_data = 22'h0;
    go = 1'b0;
    go_line = 4'h0;
    go_wait = 2'h0;
    void'($urandom(20092));
    repeat (20) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    check(31'(cpu_irq_q), 31'h0);
    // indices past the table must leave it untouched
    for (int i = 0; i < 101; i++)
    begin
      vec_wr_en = 1'b1;
      vec_wr_idx = 7'(i);
      vec_wr_data = 22'($urandom);
      if (i < 96)
        vt[i] = vec_wr_data;
      @(posedge clk_sys);
      #1;
    end
    vec_wr_en = 1'b0;
    for (int r = 0; r < 24; r++)
    begin
      g = r % 8;
      p = 8'($urandom);
      e = 8'($urandom);
      periph_req[g*8 +: 8] = p;
      req_enable[g*8 +: 8] = e;
      pend = p & e;
      for (int k = 0; k < 8; k++)
        if (g * 8 + k >= 45)
          pend[k] = 1'b0;
      @(posedge clk_sys);
      #1;
      periph_req = '0;
      @(posedge clk_sys);
      #1;
      check(31'(cpu_irq_q), 31'(pend != 8'h00) << g);
      // one answer per pending bit, lowest first, then a spurious one
      while (1)
      begin
        b = 0;
        for (int k = 7; k >= 0; k--)
          if (pend[k])
            b = k;
        // fresh vector just before the ack: a prompt ack must read the new value
        vec_wr_en = 1'b1;
        vec_wr_idx = 7'(g * 8 + b);
        vec_wr_data = 22'($urandom);
        vt[g * 8 + b] = vec_wr_data;
        @(posedge clk_sys);
        #1;
        vec_wr_en = 1'b0;
        q.push_back(pend == 8'h00 ? {2'b10, 29'h0} : {2'b01, 7'(g * 8 + b), vt[g * 8 + b]});
        ack_line(g);
        if (pend == 8'h00)
          break;
        pend[b] = 1'b0;
      end
      check(31'(cpu_irq_q), 31'h0);
    end
    q.push_back({2'b10, 29'h0});
    ack_line(12);
    check(31'(q.size()), 31'h0);
    tally_and_finish();
  end
endmodule // tb_peripheral_irq_expander
